// ==== cmx_map.svh ====
`ifndef CMX_MAP_SVH
`define CMX_MAP_SVH

`define CMX_OFF_CMD    12'h000
`define CMX_OFF_ACC1   12'h004
`define CMX_OFF_ACC2   12'h008
`define CMX_OFF_INDEX  12'h00C
`define CMX_OFF_STATUS 12'h010
`define CMX_OFF_RESULT 12'h014
`define CMX_OFF_PMAP_A 12'h100
`define CMX_OFF_PMAP_B 12'h180
`define CMX_PMAP_MASK  12'hF80

`define CMX_STAT_PROT  11
`define CMX_STAT_USER  12
`define CMX_PTR_DIR    15
`define CMX_MAP_LAST   5'h1F
`define CMX_MAP_STEP   16'h0020
`define CMX_STATUS_RST 16'h0000

`define CMX_RES_BUSY   0
`define CMX_RES_DONE   1
`define CMX_RES_VIOL   2
`define CMX_RES_INTR   3

`endif

// ==== cmx_pkg.sv ====
package cmx_pkg;

  typedef enum logic [3:0] {
    CMX_NOP,
    CMX_MOVE_BYTES_FROM_ALT,
    CMX_MOVE_BYTES_INTO_ALT,
    CMX_MOVE_BYTES_WITHIN_ALT,
    CMX_MOVE_WORDS_FROM_ALT,
    CMX_MOVE_WORDS_INTO_ALT,
    CMX_MOVE_WORDS_WITHIN_ALT,
    CMX_PORT_A_MAP_XFER_ACC1,
    CMX_PORT_A_MAP_XFER_ACC2,
    CMX_PORT_B_MAP_XFER_ACC1,
    CMX_PORT_B_MAP_XFER_ACC2,
    CMX_READ_STATUS_TO_ACC1,
    CMX_READ_STATUS_TO_ACC2
  } cmx_cmd_t;

  typedef enum logic [1:0] {
    CMX_MAP_SYS,
    CMX_MAP_USER,
    CMX_MAP_PORT_A,
    CMX_MAP_PORT_B
  } cmx_map_t;

  typedef enum logic [2:0] {
    CMX_S_IDLE,
    CMX_S_CHECK,
    CMX_S_RD_SRC,
    CMX_S_RD_DST,
    CMX_S_WR_DST,
    CMX_S_MAP
  } cmx_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    cmx_map_t    map;
    logic [14:0] addr;
    logic [15:0] wdata;
  } cmx_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
    logic        rd_viol;
    logic        wr_viol;
  } cmx_mem_rsp_t;

endpackage

// ==== cmx_xfer_engine.sv ====
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cmx_map.svh"

module cmx_xfer_engine (
  input  wire logic                  clk_sys,         // 40 MHz clock
  input  wire logic                  rst_n,           // Async reset
  input  wire logic                  hsel,            // AHB select
  input  wire logic [31:0]           haddr,           // AHB address
  input  wire logic [1:0]            htrans,          // AHB transfer type
  input  wire logic                  hwrite,          // AHB write
  input  wire logic [2:0]            hsize,           // AHB size
  input  wire logic                  hready,          // AHB ready in
  input  wire logic [31:0]           hwdata,          // AHB write data
  output logic                       hreadyout,       // AHB ready out
  output logic                       hresp,           // AHB response
  output logic [31:0]                hrdata,          // AHB read data
  output cmx_pkg::cmx_mem_req_t      mem_req_o,       // Memory request
  input  wire cmx_pkg::cmx_mem_rsp_t mem_rsp_i,       // Memory answer
  input  wire logic                  port_ctrl_cycle, // Port ctrl access
  input  wire logic                  intr_pend,       // Pending interrupt
  output logic                       prot_viol        // Fault pulse
);

  cmx_pkg::cmx_state_t   state_q;
  cmx_pkg::cmx_cmd_t     cmd_q;
  cmx_pkg::cmx_mem_req_t mem_q;
  logic [15:0]           acc1_q;
  logic [15:0]           acc2_q;
  logic [15:0]           idx_q;
  logic [15:0]           status_q;
  logic [15:0]           src_q;
  logic [15:0]           pmap_a_q [32];
  logic [15:0]           pmap_b_q [32];
  logic [4:0]            mi_q;
  logic [3:0]            res_q;
  logic                  viol_q;
  logic                  wr_q;
  logic [11:0]           wa_q;
  logic                  hready_q;
  logic [31:0]           hrdata_q;

  logic                  is_byte;
  logic                  is_word;
  logic                  is_map;
  logic                  src_alt;
  logic                  dst_alt;
  logic                  use_acc2;
  logic                  port_b;
  logic                  prot;
  logic                  rd_bad;
  logic                  wr_bad;
  logic                  byte_last;
  logic                  start;
  logic [15:0]           ptr;
  logic [15:0]           step;
  logic [15:0]           idx_nxt;
  logic [15:0]           map_word;
  logic [14:0]           src_wa;
  logic [14:0]           dst_wa;
  cmx_pkg::cmx_map_t     en_map;
  cmx_pkg::cmx_map_t     alt_map;
  cmx_pkg::cmx_map_t     src_map;
  cmx_pkg::cmx_map_t     dst_map;
  logic [31:0]           rd_mux;

  assign is_byte = cmd_q == cmx_pkg::CMX_MOVE_BYTES_FROM_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_BYTES_INTO_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_BYTES_WITHIN_ALT;
  assign is_word = cmd_q == cmx_pkg::CMX_MOVE_WORDS_FROM_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_WORDS_INTO_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_WORDS_WITHIN_ALT;
  assign is_map  = cmd_q == cmx_pkg::CMX_PORT_A_MAP_XFER_ACC1
                || cmd_q == cmx_pkg::CMX_PORT_A_MAP_XFER_ACC2
                || cmd_q == cmx_pkg::CMX_PORT_B_MAP_XFER_ACC1
                || cmd_q == cmx_pkg::CMX_PORT_B_MAP_XFER_ACC2;
  assign src_alt = cmd_q == cmx_pkg::CMX_MOVE_BYTES_FROM_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_BYTES_WITHIN_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_WORDS_FROM_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_WORDS_WITHIN_ALT;
  assign dst_alt = cmd_q == cmx_pkg::CMX_MOVE_BYTES_INTO_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_BYTES_WITHIN_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_WORDS_INTO_ALT
                || cmd_q == cmx_pkg::CMX_MOVE_WORDS_WITHIN_ALT;
  assign use_acc2 = cmd_q == cmx_pkg::CMX_PORT_A_MAP_XFER_ACC2
                 || cmd_q == cmx_pkg::CMX_PORT_B_MAP_XFER_ACC2;
  assign port_b   = cmd_q == cmx_pkg::CMX_PORT_B_MAP_XFER_ACC1
                 || cmd_q == cmx_pkg::CMX_PORT_B_MAP_XFER_ACC2;
  assign prot     = status_q[`CMX_STAT_PROT];

  // Alternate map is the one not currently selected
  assign en_map  = status_q[`CMX_STAT_USER] ? cmx_pkg::CMX_MAP_USER
                                            : cmx_pkg::CMX_MAP_SYS;
  assign alt_map = status_q[`CMX_STAT_USER] ? cmx_pkg::CMX_MAP_SYS
                                            : cmx_pkg::CMX_MAP_USER;
  assign src_map = src_alt ? alt_map : en_map;
  assign dst_map = dst_alt ? alt_map : en_map;

  // Port controller cycles never raise a memory fault; the protected-mode check can still fault
  assign rd_bad = mem_rsp_i.ack && mem_rsp_i.rd_viol
               && !port_ctrl_cycle;
  assign wr_bad = mem_rsp_i.ack && mem_rsp_i.wr_viol
               && !port_ctrl_cycle;

  assign byte_last = is_byte && idx_q == 16'h0001;
  assign step      = (is_byte && !byte_last) ? 16'h0002 : 16'h0001;
  assign idx_nxt   = idx_q - step;
  assign src_wa    = is_byte ? acc1_q[15:1] : acc1_q[14:0];
  assign dst_wa    = is_byte ? acc2_q[15:1] : acc2_q[14:0];
  assign ptr       = use_acc2 ? acc2_q : acc1_q;
  // First store word is entry 0 even after an aborted transfer
  assign map_word  = port_b ? pmap_b_q[0] : pmap_a_q[0];
  assign start     = wr_q && wa_q == `CMX_OFF_CMD
                  && state_q == cmx_pkg::CMX_S_IDLE;

  // Bus address phase, zero wait states
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q     <= 1'b0;
      wa_q     <= 12'h000;
      hready_q <= 1'b0;
    end
    else
    begin
      hready_q <= 1'b1;
      wr_q     <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        wa_q <= haddr[11:0];
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if ((haddr[11:0] & `CMX_PMAP_MASK) == `CMX_OFF_PMAP_A)
      rd_mux = {16'h0000, pmap_a_q[haddr[6:2]]};
    else if ((haddr[11:0] & `CMX_PMAP_MASK) == `CMX_OFF_PMAP_B)
      rd_mux = {16'h0000, pmap_b_q[haddr[6:2]]};
    else if (haddr[11:0] == `CMX_OFF_CMD)
      rd_mux = {28'h0000000, cmd_q};
    else if (haddr[11:0] == `CMX_OFF_ACC1)
      rd_mux = {16'h0000, acc1_q};
    else if (haddr[11:0] == `CMX_OFF_ACC2)
      rd_mux = {16'h0000, acc2_q};
    else if (haddr[11:0] == `CMX_OFF_INDEX)
      rd_mux = {16'h0000, idx_q};
    else if (haddr[11:0] == `CMX_OFF_STATUS)
      rd_mux = {16'h0000, status_q};
    else if (haddr[11:0] == `CMX_OFF_RESULT)
      rd_mux = {28'h0000000, res_q};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_q <= 32'h0000_0000;
    else if (hsel && hready && htrans[1] && !hwrite)
      hrdata_q <= rd_mux;
  end

  // Move and map transfer engine with its working registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= cmx_pkg::CMX_S_IDLE;
      cmd_q    <= cmx_pkg::CMX_NOP;
      mem_q    <= '0;
      acc1_q   <= 16'h0000;
      acc2_q   <= 16'h0000;
      idx_q    <= 16'h0000;
      status_q <= `CMX_STATUS_RST;
      src_q    <= 16'h0000;
      mi_q     <= 5'h00;
      res_q    <= 4'h0;
      viol_q   <= 1'b0;
      for (int i = 0; i < 32; i++)
      begin
        pmap_a_q[i] <= 16'h0000;
        pmap_b_q[i] <= 16'h0000;
      end
    end
    else
    begin
      viol_q <= 1'b0;
      case (state_q)
        cmx_pkg::CMX_S_IDLE:
        begin
          // Working registers only writable while idle
          if (wr_q && wa_q == `CMX_OFF_ACC1)
            acc1_q <= hwdata[15:0];
          if (wr_q && wa_q == `CMX_OFF_ACC2)
            acc2_q <= hwdata[15:0];
          if (wr_q && wa_q == `CMX_OFF_INDEX)
            idx_q <= hwdata[15:0];
          if (wr_q && wa_q == `CMX_OFF_STATUS)
            status_q <= hwdata[15:0];
          if (start)
          begin
            cmd_q   <= cmx_pkg::cmx_cmd_t'(hwdata[3:0]);
            res_q   <= 4'h1;
            state_q <= cmx_pkg::CMX_S_CHECK;
          end
        end
        cmx_pkg::CMX_S_CHECK:
        begin
          mi_q <= 5'h00;
          if (cmd_q == cmx_pkg::CMX_READ_STATUS_TO_ACC1)
          begin
            acc1_q  <= status_q;
            res_q   <= 4'h2;
            state_q <= cmx_pkg::CMX_S_IDLE;
          end
          else if (cmd_q == cmx_pkg::CMX_READ_STATUS_TO_ACC2)
          begin
            acc2_q  <= status_q;
            res_q   <= 4'h2;
            state_q <= cmx_pkg::CMX_S_IDLE;
          end
          else if (prot && ((is_byte || is_word) && dst_alt
                   || is_map && !ptr[`CMX_PTR_DIR]))
          begin
            viol_q  <= 1'b1;
            res_q   <= 4'h6;
            state_q <= cmx_pkg::CMX_S_IDLE;
          end
          else if ((is_byte || is_word) && idx_q == 16'h0000)
          begin
            res_q   <= 4'h2;
            state_q <= cmx_pkg::CMX_S_IDLE;
          end
          else if (is_byte || is_word)
          begin
            mem_q   <= '{1'b1, 1'b0, src_map, src_wa, 16'h0000};
            state_q <= cmx_pkg::CMX_S_RD_SRC;
          end
          else if (is_map)
          begin
            mem_q   <= '{1'b1, ptr[`CMX_PTR_DIR], en_map,
                        ptr[14:0], map_word};
            state_q <= cmx_pkg::CMX_S_MAP;
          end
          else
          begin
            res_q   <= 4'h2;
            state_q <= cmx_pkg::CMX_S_IDLE;
          end
        end
        cmx_pkg::CMX_S_RD_SRC:
        begin
          if (mem_rsp_i.ack)
          begin
            mem_q.req <= 1'b0;
            src_q     <= mem_rsp_i.rdata;
            if (rd_bad)
            begin
              viol_q  <= 1'b1;
              res_q   <= 4'h6;
              state_q <= cmx_pkg::CMX_S_IDLE;
            end
            else if (byte_last)
            begin
              mem_q   <= '{1'b1, 1'b0, dst_map, dst_wa, 16'h0000};
              state_q <= cmx_pkg::CMX_S_RD_DST;
            end
            else
            begin
              mem_q   <= '{1'b1, 1'b1, dst_map, dst_wa, mem_rsp_i.rdata};
              state_q <= cmx_pkg::CMX_S_WR_DST;
            end
          end
        end
        cmx_pkg::CMX_S_RD_DST:
        begin
          if (mem_rsp_i.ack)
          begin
            mem_q.req <= 1'b0;
            if (rd_bad)
            begin
              viol_q  <= 1'b1;
              res_q   <= 4'h6;
              state_q <= cmx_pkg::CMX_S_IDLE;
            end
            else
            begin
              mem_q   <= '{1'b1, 1'b1, dst_map, dst_wa,
                          {src_q[15:8], mem_rsp_i.rdata[7:0]}};
              state_q <= cmx_pkg::CMX_S_WR_DST;
            end
          end
        end
        cmx_pkg::CMX_S_WR_DST:
        begin
          if (mem_rsp_i.ack)
          begin
            mem_q.req <= 1'b0;
            if (wr_bad)
            begin
              viol_q  <= 1'b1;
              res_q   <= 4'h6;
              state_q <= cmx_pkg::CMX_S_IDLE;
            end
            else
            begin
              acc1_q <= acc1_q + step;
              acc2_q <= acc2_q + step;
              idx_q  <= idx_nxt;
              if (idx_nxt == 16'h0000)
              begin
                res_q   <= 4'h2;
                state_q <= cmx_pkg::CMX_S_IDLE;
              end
              else if (intr_pend)
              begin
                // Byte steps are byte pairs, so this stop is even
                res_q   <= 4'h8;
                state_q <= cmx_pkg::CMX_S_IDLE;
              end
              else
              begin
                mem_q   <= '{1'b1, 1'b0, src_map,
                            is_byte ? acc1_q[15:1] + 15'h0001
                                    : acc1_q[14:0] + 15'h0001,
                            16'h0000};
                state_q <= cmx_pkg::CMX_S_RD_SRC;
              end
            end
          end
        end
        cmx_pkg::CMX_S_MAP:
        begin
          if (mem_rsp_i.ack)
          begin
            mem_q.req <= 1'b0;
            if (mem_q.we ? wr_bad : rd_bad)
            begin
              viol_q  <= 1'b1;
              res_q   <= 4'h6;
              state_q <= cmx_pkg::CMX_S_IDLE;
            end
            else
            begin
              if (!mem_q.we && port_b)
                pmap_b_q[mi_q] <= mem_rsp_i.rdata;
              if (!mem_q.we && !port_b)
                pmap_a_q[mi_q] <= mem_rsp_i.rdata;
              mi_q <= mi_q + 5'h01;
              if (mi_q == `CMX_MAP_LAST)
              begin
                if (use_acc2)
                  acc2_q <= acc2_q + `CMX_MAP_STEP;
                else
                  acc1_q <= acc1_q + `CMX_MAP_STEP;
                res_q   <= 4'h2;
                state_q <= cmx_pkg::CMX_S_IDLE;
              end
              else
              begin
                mem_q <= '{1'b1, mem_q.we, en_map,
                          mem_q.addr + 15'h0001,
                          port_b ? pmap_b_q[mi_q + 5'h01]
                                 : pmap_a_q[mi_q + 5'h01]};
              end
            end
          end
        end
        default:
          state_q <= cmx_pkg::CMX_S_IDLE;
      endcase
    end
  end

  assign hreadyout = hready_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign mem_req_o = mem_q;
  assign prot_viol = viol_q;

  a_zero_count_nop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_CHECK && (is_byte || is_word) && !dst_alt
    && idx_q == 16'h0000 |=> state_q == cmx_pkg::CMX_S_IDLE
    && !mem_q.req && res_q == 4'h2)
    else $error("zero count did not finish as no-operation");

  a_prot_into_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_CHECK && prot && dst_alt
    |=> prot_viol && !mem_q.req ##1 !prot_viol)
    else $error("protected into or within move was not refused");

  a_map_load_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_CHECK && prot && is_map
    && !ptr[`CMX_PTR_DIR] |=> prot_viol && !mem_q.req)
    else $error("protected map load was not refused");

  a_map_ptr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_MAP && mem_rsp_i.ack && !viol_q
    && mi_q == `CMX_MAP_LAST && !(mem_q.we ? wr_bad : rd_bad) && !use_acc2
    |=> acc1_q == $past(acc1_q) + `CMX_MAP_STEP)
    else $error("map pointer not advanced by 32");

  a_byte_intr_even: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(res_q[`CMX_RES_INTR]) && is_byte && !byte_last
    |-> acc1_q[0] == $past(acc1_q[0]) && idx_q != 16'h0000)
    else $error("byte move stopped on an odd byte");

  a_done_count_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_WR_DST && mem_rsp_i.ack && !wr_bad
    && idx_nxt == 16'h0000 |=> idx_q == 16'h0000
    && state_q == cmx_pkg::CMX_S_IDLE)
    else $error("completed move left a nonzero count");

  a_status_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_CHECK
    && cmd_q == cmx_pkg::CMX_READ_STATUS_TO_ACC2
    |=> acc2_q == status_q && $stable(status_q))
    else $error("status copy wrong or status altered");

  a_src_alt_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_RD_SRC && mem_q.req && src_alt
    |-> mem_q.map == alt_map && mem_q.map != en_map)
    else $error("source not read through alternate map");

  a_dst_en_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == cmx_pkg::CMX_S_WR_DST && mem_q.req && !dst_alt
    |-> mem_q.map == en_map && mem_q.we)
    else $error("destination not written through enabled map");

  a_bypass_port: assert property (@(posedge clk_sys) disable iff (!rst_n)
    port_ctrl_cycle && state_q != cmx_pkg::CMX_S_CHECK |=> !prot_viol)
    else $error("port controller access raised a fault");

endmodule

// ==== cmx_mem_model.sv ====
`timescale 1ns/1ps
module cmx_mem_model (
  input  wire logic                  clk_sys, // Clock
  input  wire logic                  rst_n,   // Reset, active low
  input  wire cmx_pkg::cmx_mem_req_t req_i,   // Request
  input  wire logic [1:0]            dly,     // Extra wait cycles
  input  wire logic [8:0]            bad_loc, // Faulting location
  output cmx_pkg::cmx_mem_rsp_t      rsp_o    // Answer
);
  logic [15:0] mem [512];
  logic [1:0]  wait_q;
  logic [8:0]  loc;
  logic        hit;
  // Port maps never reach memory, so 9'h1FF means no fault
  assign loc = {req_i.map, req_i.addr[6:0]};
  assign hit = loc == bad_loc;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wait_q <= 2'h0;
      rsp_o  <= '0;
    end
    else if (req_i.req && !rsp_o.ack && wait_q == dly)
    begin
      wait_q        <= 2'h0;
      rsp_o.ack     <= 1'b1;
      rsp_o.rdata   <= mem[loc];
      rsp_o.rd_viol <= hit && !req_i.we;
      rsp_o.wr_viol <= hit && req_i.we;
      if (req_i.we && !hit)
        mem[loc] <= req_i.wdata;
    end
    else
    begin
      wait_q        <= (req_i.req && !rsp_o.ack) ? wait_q + 2'h1 : 2'h0;
      rsp_o.ack     <= 1'b0;
      rsp_o.rd_viol <= 1'b0;
      rsp_o.wr_viol <= 1'b0;
      // Stale data is not left standing
      rsp_o.rdata   <= ~rsp_o.rdata;
    end
endmodule

// ==== cmx_xfer_engine_bench.sv ====
`timescale 1ns/1ps
module cmx_xfer_engine_bench;
  logic clk_sys, rst_n, hwrite, hready, hresp, prot_viol, intr_pend, pcc;
  logic [1:0] htrans, dly;
  logic [8:0] bad_loc;
  logic [31:0] haddr, hwdata, hrdata;
  cmx_pkg::cmx_mem_req_t mreq;
  cmx_pkg::cmx_mem_rsp_t mrsp;
  int bad_count, n_tests, n_viol;
  cmx_xfer_engine u_cmx_xfer_engine (.clk_sys(clk_sys), .rst_n(rst_n),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .mem_req_o(mreq), .mem_rsp_i(mrsp),
    .port_ctrl_cycle(pcc), .intr_pend(intr_pend), .prot_viol(prot_viol));
  cmx_mem_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .req_i(mreq),
    .dly(dly), .bad_loc(bad_loc), .rsp_o(mrsp));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (prot_viol === 1'b1)
      n_viol++;
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h00000, a};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  // Load pointers and count, start, poll until idle
  task automatic run(input logic [15:0] a1, input logic [15:0] a2,
                     input logic [15:0] n, input logic [3:0] c);
    logic [31:0] r;
    wr(12'h004, {16'h0, a1});
    wr(12'h008, {16'h0, a2});
    wr(12'h00C, {16'h0, n});
    wr(12'h000, {28'h0, c});
    do xfer(1'b0, 12'h014, 32'h0, r); while (r[0] !== 1'b0);
  endtask
  task automatic t_reset;
    rd(12'h010, 32'h0);
    rd(12'h014, 32'h0);
    rd(12'h020, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_moves;
    u_mem.mem[9'h084] = 16'h1111;
    u_mem.mem[9'h085] = 16'h2222;
    run(16'h0004, 16'h0008, 16'h0002, 4'h4);
    chk({16'h0, u_mem.mem[9'h008]}, 32'h1111);
    chk({16'h0, u_mem.mem[9'h009]}, 32'h2222);
    rd(12'h004, 32'h6);
    rd(12'h008, 32'hA);
    rd(12'h00C, 32'h0);
    u_mem.mem[9'h088] = 16'hA1B2;
    u_mem.mem[9'h089] = 16'hC3D4;
    u_mem.mem[9'h00D] = 16'hEEFF;
    run(16'h0010, 16'h0018, 16'h0003, 4'h1);
    chk({16'h0, u_mem.mem[9'h00C]}, 32'hA1B2);
    chk({16'h0, u_mem.mem[9'h00D]}, 32'hC3FF);
    rd(12'h008, 32'h1B);
    u_mem.mem[9'h004] = 16'h3333;
    wr(12'h010, 32'h1000);
    run(16'h0004, 16'h0010, 16'h0001, 4'h6);
    chk({16'h0, u_mem.mem[9'h010]}, 32'h3333);
    run(16'h0004, 16'h0010, 16'h0000, 4'h2);
    rd(12'h014, 32'h2);
    rd(12'h004, 32'h4);
    run(16'h0006, 16'h0010, 16'h0000, 4'h1);
    rd(12'h014, 32'h2);
    rd(12'h004, 32'h6);
    $display("string moves done");
  endtask
  task automatic t_prot;
    wr(12'h010, 32'h0800);
    run(16'h0000, 16'h0000, 16'h0001, 4'h3);
    rd(12'h014, 32'h6);
    run(16'h0040, 16'h0000, 16'h0000, 4'h7);
    rd(12'h014, 32'h6);
    run(16'h0040, 16'h0000, 16'h0000, 4'hC);
    rd(12'h008, 32'h0800);
    rd(12'h010, 32'h0800);
    chk(n_viol, 2);
    wr(12'h010, 32'h0);
    $display("protected mode done");
  endtask
  task automatic t_maps;
    u_mem.mem[9'h040] = 16'h1234;
    u_mem.mem[9'h05F] = 16'h00AB;
    run(16'h0040, 16'h8020, 16'h0000, 4'h7);
    rd(12'h100, 32'h1234);
    rd(12'h17C, 32'h00AB);
    rd(12'h004, 32'h0060);
    run(16'h0000, 16'h8020, 16'h0000, 4'h8);
    chk({16'h0, u_mem.mem[9'h03F]}, 32'h00AB);
    rd(12'h008, 32'h8040);
    run(16'h0000, 16'h8020, 16'h0000, 4'hA);
    chk({16'h0, u_mem.mem[9'h020]}, 32'h0);
    $display("map transfers done");
  endtask
  task automatic t_stop;
    dly <= 2'h1;
    bad_loc <= 9'h081;
    run(16'h0000, 16'h0018, 16'h0003, 4'h4);
    rd(12'h014, 32'h4, 32'h4);
    rd(12'h00C, 32'h2);
    chk(n_viol, 3);
    bad_loc <= 9'h1FF;
    intr_pend <= 1'b1;
    run(16'h0000, 16'h0018, 16'h0002, 4'h4);
    rd(12'h014, 32'h8, 32'h8);
    rd(12'h00C, 32'h1);
    run(16'h0020, 16'h0040, 16'h0004, 4'h1);
    rd(12'h014, 32'h8, 32'h8);
    rd(12'h004, 32'h22);
    rd(12'h00C, 32'h2);
    intr_pend <= 1'b0;
    run(16'h0001, 16'h0019, 16'h0001, 4'h4);
    rd(12'h00C, 32'h0);
    u_mem.mem[9'h080] = 16'h5A5A;
    bad_loc <= 9'h080;
    pcc <= 1'b1;
    run(16'h0000, 16'h0030, 16'h0001, 4'h4);
    rd(12'h014, 32'h2);
    chk({16'h0, u_mem.mem[9'h030]}, 32'h5A5A);
    chk(n_viol, 3);
    pcc <= 1'b0;
    bad_loc <= 9'h1FF;
    $display("fault and interrupt done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    intr_pend = 1'b0;
    pcc = 1'b0;
    dly = 2'h0;
    bad_loc = 9'h1FF;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_moves();
    t_prot();
    t_maps();
    t_stop();
    tally_and_finish();
  end
  initial
  begin
    #(25 * 20000);
    bad_count++;
    tally_and_finish();
  end
endmodule
